// ==== rtl/nrs_host.sv ====
`timescale 1ns/1ps
`include "nrs_params.svh"
module nrs_host
   import nrs_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [7:0]  io_i,
   input  wire logic        ready_busy_n,
   output nrs_pin_t         pins
);
   localparam int WB_C = `NRS_WB_CYC;

   ////////////////////////////////////////////////////////////////////////////////
   // Decode helpers
   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a == `NRS_REG_CMD) || (a == `NRS_REG_COL) || (a == `NRS_REG_ROW) ||
                (a == `NRS_REG_STAT) || (a == `NRS_REG_DATA);
   endfunction

   // Command sequence for each operation except the single byte read, which has none
   function automatic nrs_seq_t seq_of(input logic [2:0] op);
      seq_of = '0;
      case (op)
         `NRS_OP_PAGE: seq_of = '{`NRS_C_READ, `NRS_PAGE_ADDR, 1'b1, `NRS_C_CONFIRM,
                                  1'b1, 1'b0};
         `NRS_OP_RANDOM: seq_of = '{`NRS_C_RAND, `NRS_COL_ADDR, 1'b1, `NRS_C_RAND_CONF,
                                    1'b0, 1'b0};
         `NRS_OP_CACHE: seq_of = '{`NRS_C_CACHE, 3'd0, 1'b0, 8'h00, 1'b1, 1'b0};
         `NRS_OP_LAST: seq_of = '{`NRS_C_LAST, 3'd0, 1'b0, 8'h00, 1'b1, 1'b0};
         `NRS_OP_ID: seq_of = '{`NRS_C_ID, 3'd1, 1'b0, 8'h00, 1'b0, 1'b1};
         `NRS_OP_STATUS: seq_of = '{`NRS_C_STATUS, 3'd0, 1'b0, 8'h00, 1'b0, 1'b0};
         `NRS_OP_RDMODE: seq_of = '{`NRS_C_READ, 3'd0, 1'b0, 8'h00, 1'b0, 1'b0};
         default: seq_of = '0;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic       rb_m_r, rb_s_r;      // Ready/busy, two stages
   logic [7:0] io_m_r, io_s_r;      // Data in, two stages

   // Two flops before any use
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rb_m_r <= 1'b0;
         rb_s_r <= 1'b0;
         io_m_r <= 8'h00;
         io_s_r <= 8'h00;
      end else begin
         rb_m_r <= ready_busy_n;
         rb_s_r <= rb_m_r;
         io_m_r <= io_i;
         io_s_r <= io_m_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State
   nrs_state_t  state_r, state_nxt;   // Sequencer state
   nrs_seq_t    seq_r, seq_nxt;       // Active sequence
   logic [2:0]  op_r, op_nxt;         // Active operation
   logic [2:0]  step_r, step_nxt;     // Cycle index in sequence
   logic [3:0]  cnt_r, cnt_nxt;       // Phase counter
   logic [15:0] col_r, col_nxt;       // Column address
   logic [23:0] row_r, row_nxt;       // Row address
   logic [23:0] page_r, page_nxt;     // Page held in the device
   logic        page_ok_r, page_ok_nxt;
   logic        smode_r, smode_nxt;   // Device answering status
   logic        idmode_r, idmode_nxt; // Device answering identifier
   logic        refused_r, refused_nxt;
   logic [7:0]  data_r, data_nxt;     // Last byte read
   logic [31:0] prdata_r, prdata_nxt;
   logic        err_r, err_nxt;
   nrs_pin_t    pins_r, pins_nxt;

   logic        wr, cmd_wr, legal, start, last_step;
   logic [2:0]  op_w, aidx;
   logic [39:0] addr40;
   logic [7:0]  step_byte;

   assign pready  = 1'b1;
   assign prdata  = prdata_r;
   assign pslverr = err_r;
   assign pins    = pins_r;

   ////////////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb begin
      wr          = psel && penable && pwrite;
      op_w        = pwdata[2:0];
      cmd_wr      = wr && (paddr == `NRS_REG_CMD);
      last_step   = (step_r == (seq_r.naddr + {2'b00, seq_r.two}));
      aidx        = step_r - 3'd1;
      addr40      = seq_r.zero_addr ? 40'h00_0000_0000 : {row_r, col_r};
      step_byte   = (step_r == 3'd0) ? seq_r.cmd1 :
                    (step_r > seq_r.naddr) ? seq_r.cmd2 : addr40[{aidx, 3'b000} +: 8];
      // Legality of the requested operation
      case (op_w)
         `NRS_OP_RANDOM: legal = page_ok_r;
         `NRS_OP_CACHE:  legal = page_ok_r &&
                                 (page_r[`NRS_PAGE_BITS-1:0] != '1);
         `NRS_OP_LAST:   legal = page_ok_r;
         `NRS_OP_BYTE:   legal = rb_s_r || smode_r;
         default:        legal = 1'b1;
      endcase
      legal       = legal && (state_r == ST_IDLE);
      start       = cmd_wr && legal;
      state_nxt   = state_r;
      seq_nxt     = seq_r;
      op_nxt      = op_r;
      step_nxt    = step_r;
      cnt_nxt     = (cnt_r != 4'd0) ? cnt_r - 4'd1 : 4'd0;
      col_nxt     = col_r;
      row_nxt     = row_r;
      page_nxt    = page_r;
      page_ok_nxt = page_ok_r;
      smode_nxt   = smode_r;
      idmode_nxt  = idmode_r;
      data_nxt    = data_r;
      // Sticky refusal, set wins over clear
      refused_nxt = (cmd_wr && !legal) || (refused_r && !(wr &&
                    (paddr == `NRS_REG_STAT) && pwdata[`NRS_ST_REFUSED]));
      // Address registers, frozen while a sequence runs
      if (wr && (state_r == ST_IDLE) && (paddr == `NRS_REG_COL)) begin
         col_nxt = pwdata[15:0];
      end
      if (wr && (state_r == ST_IDLE) && (paddr == `NRS_REG_ROW)) begin
         row_nxt = pwdata[23:0];
      end
      case (state_r)
         ST_IDLE: begin
            if (start && (op_w == `NRS_OP_BYTE)) begin
               state_nxt = ST_RLOW;
               cnt_nxt   = 4'(`NRS_RL_CYC - 1);
            end else if (start) begin
               op_nxt     = op_w;
               seq_nxt    = seq_of(op_w);
               step_nxt   = 3'd0;
               state_nxt  = ST_WLOW;
               cnt_nxt    = 4'(`NRS_WP_CYC - 1);
               smode_nxt  = (op_w == `NRS_OP_STATUS);
               idmode_nxt = (op_w == `NRS_OP_ID);
               if (op_w == `NRS_OP_PAGE) begin
                  page_nxt    = row_r;
                  page_ok_nxt = 1'b1;
               end else if (op_w == `NRS_OP_CACHE) begin
                  page_nxt = page_r + 24'd1;
               end else if (op_w == `NRS_OP_LAST) begin
                  page_ok_nxt = 1'b0;
               end
            end
         end
         ST_WLOW: begin
            if (cnt_r == 4'd0) begin
               state_nxt = ST_WHIGH;
               cnt_nxt   = 4'(`NRS_WH_CYC - 1);
            end
         end
         ST_WHIGH: begin
            if ((cnt_r == 4'd0) && !last_step) begin
               step_nxt  = step_r + 3'd1;
               state_nxt = ST_WLOW;
               cnt_nxt   = 4'(`NRS_WP_CYC - 1);
            end else if ((cnt_r == 4'd0) && seq_r.wait_rb) begin
               state_nxt = ST_TWB;
               cnt_nxt   = 4'(`NRS_WB_CYC - 1);
            end else if (cnt_r == 4'd0) begin
               state_nxt = ST_IDLE;
            end
         end
         ST_TWB: begin
            if (cnt_r == 4'd0) begin
               state_nxt = ST_WAITRB;
            end
         end
         ST_WAITRB: begin
            if (rb_s_r) begin
               state_nxt = ST_IDLE;
            end
         end
         ST_RLOW: begin
            if (cnt_r == 4'd0) begin
               data_nxt  = io_s_r;
               state_nxt = ST_RHIGH;
               cnt_nxt   = 4'(`NRS_RH_CYC - 1);
            end
         end
         ST_RHIGH: begin
            if (cnt_r == 4'd0) begin
               state_nxt = ST_IDLE;
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
      // Pins follow the current state
      pins_nxt               = pins_r;
      pins_nxt.ce_n          = (state_r == ST_IDLE);
      pins_nxt.we_n          = (state_r != ST_WLOW);
      pins_nxt.read_strobe_n = (state_r != ST_RLOW);
      pins_nxt.io_oe         = (state_r == ST_WLOW) || (state_r == ST_WHIGH);
      if (state_r == ST_WLOW) begin
         pins_nxt.io_o = step_byte;
         pins_nxt.cle  = (step_r == 3'd0) || (step_r > seq_r.naddr);
         pins_nxt.ale  = !((step_r == 3'd0) || (step_r > seq_r.naddr));
      end else if (state_r != ST_WHIGH) begin
         pins_nxt.cle = 1'b0;
         pins_nxt.ale = 1'b0;
      end
      // APB read data and error, formed in setup phase
      err_nxt    = psel && !penable && !addr_ok(paddr);
      prdata_nxt = 32'h0000_0000;
      case (paddr)
         `NRS_REG_CMD:  prdata_nxt = {29'h0000_0000, op_r};
         `NRS_REG_COL:  prdata_nxt = {16'h0000, col_r};
         `NRS_REG_ROW:  prdata_nxt = {8'h00, row_r};
         `NRS_REG_STAT: prdata_nxt = {26'h000_0000, page_ok_r, idmode_r, refused_r,
                                      smode_r, rb_s_r, state_r != ST_IDLE};
         `NRS_REG_DATA: prdata_nxt = {24'h00_0000, data_r};
         default:       prdata_nxt = 32'h0000_0000;
      endcase
   end

   // Register all state
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_r   <= ST_IDLE;
         seq_r     <= '0;
         op_r      <= `NRS_OP_PAGE;
         step_r    <= 3'd0;
         cnt_r     <= 4'd0;
         col_r     <= 16'h0000;
         row_r     <= 24'h00_0000;
         page_r    <= 24'h00_0000;
         page_ok_r <= 1'b0;
         smode_r   <= 1'b0;
         idmode_r  <= 1'b0;
         refused_r <= 1'b0;
         data_r    <= 8'h00;
         prdata_r  <= 32'h0000_0000;
         err_r     <= 1'b0;
         pins_r    <= '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 8'h00, 1'b0};
      end else begin
         state_r   <= state_nxt;
         seq_r     <= seq_nxt;
         op_r      <= op_nxt;
         step_r    <= step_nxt;
         cnt_r     <= cnt_nxt;
         col_r     <= col_nxt;
         row_r     <= row_nxt;
         page_r    <= page_nxt;
         page_ok_r <= page_ok_nxt;
         smode_r   <= smode_nxt;
         idmode_r  <= idmode_nxt;
         refused_r <= refused_nxt;
         data_r    <= data_nxt;
         prdata_r  <= prdata_nxt;
         err_r     <= err_nxt;
         pins_r    <= pins_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   sequence s_confirm_done;
      state_r == ST_WHIGH && cnt_r == 4'd0 && last_step && seq_r.wait_rb;
   endsequence
   sequence s_wait_phase;
      state_r == ST_TWB [*1] ##(WB_C) state_r == ST_WAITRB;
   endsequence

   latch_excl_a: assert property (pins_r.cle |-> !pins_r.ale)
      else $error("command and address latch both high");
   we_frame_a: assert property (!pins_r.we_n |-> pins_r.io_oe && !pins_r.ce_n)
      else $error("write strobe without drive or select");
   we_hold_a: assert property ($rose(pins_r.we_n) |-> $stable(pins_r.io_o) &&
                               $stable(pins_r.cle) && $stable(pins_r.ale))
      else $error("bus changed at write strobe rise");
   busy_wait_a: assert property (s_confirm_done |=> s_wait_phase)
      else $error("busy wait not entered after confirm");
   rb_release_a: assert property (state_r == ST_WAITRB && rb_s_r |=> state_r == ST_IDLE)
      else $error("ready not honoured");
   no_busy_read_a: assert property ($rose(state_r == ST_RLOW) |-> $past(rb_s_r) ||
                                    $past(smode_r))
      else $error("data strobe while busy");
   block_cross_a: assert property (cmd_wr && state_r == ST_IDLE &&
                                   op_w == `NRS_OP_CACHE &&
                                   page_r[`NRS_PAGE_BITS-1:0] == '1 |=>
                                   state_r == ST_IDLE && refused_r)
      else $error("cached read crosses block");
   strobe_width_a: assert property ($fell(pins_r.read_strobe_n) |=>
                                    !pins_r.read_strobe_n [*3] ##1 pins_r.read_strobe_n)
      else $error("read strobe too short");
   status_exit_a: assert property ($fell(smode_r) |-> $past(start))
      else $error("status mode left without command");
endmodule

// ==== rtl/nrs_params.svh ====
`ifndef NRS_PARAMS_SVH
`define NRS_PARAMS_SVH
// APB register offsets
`define NRS_REG_CMD      8'h00
`define NRS_REG_COL      8'h04
`define NRS_REG_ROW      8'h08
`define NRS_REG_STAT     8'h0C
`define NRS_REG_DATA     8'h10
// Operation codes written to the command register
`define NRS_OP_PAGE      3'h0
`define NRS_OP_RANDOM    3'h1
`define NRS_OP_CACHE     3'h2
`define NRS_OP_LAST      3'h3
`define NRS_OP_ID        3'h4
`define NRS_OP_STATUS    3'h5
`define NRS_OP_RDMODE    3'h6
`define NRS_OP_BYTE      3'h7
// Flash command bytes
`define NRS_C_READ       8'h00
`define NRS_C_CONFIRM    8'h30
`define NRS_C_RAND       8'h05
`define NRS_C_RAND_CONF  8'hE0
`define NRS_C_CACHE      8'h31
`define NRS_C_LAST       8'h3F
`define NRS_C_ID         8'h90
`define NRS_C_STATUS     8'h70
// Address cycle counts
`define NRS_PAGE_ADDR    3'd5
`define NRS_COL_ADDR     3'd2
// Status register bits
`define NRS_ST_BUSY      0
`define NRS_ST_RB        1
`define NRS_ST_SMODE     2
`define NRS_ST_REFUSED   3
`define NRS_ST_IDMODE    4
`define NRS_ST_PAGEOK    5
// Page bits within a block (64 pages)
`define NRS_PAGE_BITS    6
// Timing, nanoseconds, and derived cycles at 40 MHz
`define NRS_CLK_MHZ      40
`define NRS_T_WP_NS      25
`define NRS_T_WH_NS      25
`define NRS_T_WB_NS      100
`define NRS_T_REA_NS     25
`define NRS_T_REH_NS     25
`define NRS_CYC(ns)      (((ns) * `NRS_CLK_MHZ + 999) / 1000)
`define NRS_WP_CYC       `NRS_CYC(`NRS_T_WP_NS)
`define NRS_WH_CYC       `NRS_CYC(`NRS_T_WH_NS)
`define NRS_WB_CYC       `NRS_CYC(`NRS_T_WB_NS)
// Read low also covers the pin register and the two-stage synchroniser
`define NRS_RL_CYC       (`NRS_CYC(`NRS_T_REA_NS) + 3)
`define NRS_RH_CYC       `NRS_CYC(`NRS_T_REH_NS)
`endif

// ==== rtl/nrs_pkg.sv ====
package nrs_pkg;
   // Sequencer states
   typedef enum logic [2:0] {
      ST_IDLE, ST_WLOW, ST_WHIGH, ST_TWB, ST_WAITRB, ST_RLOW, ST_RHIGH
   } nrs_state_t;
   // Flash pins driven by the controller
   typedef struct packed {
      logic       cle;
      logic       ale;
      logic       ce_n;
      logic       we_n;
      logic       read_strobe_n;
      logic [7:0] io_o;
      logic       io_oe;
   } nrs_pin_t;
   // One command sequence
   typedef struct packed {
      logic [7:0] cmd1;
      logic [2:0] naddr;
      logic       two;
      logic [7:0] cmd2;
      logic       wait_rb;
      logic       zero_addr;
   } nrs_seq_t;
endpackage

// ==== verif/nrs_flash_model.sv ====
`timescale 1ns/1ps
// Behavioural flash die answering the controller's strobes
module nrs_flash_model
   import nrs_pkg::*;
#(
   parameter logic [7:0]  MAKER_CODE  = 8'h5A,      // Arbitrary maker value
   parameter logic [7:0]  DEVICE_CODE = 8'hA5,      // Arbitrary, one die section
   parameter logic [23:0] BOOT_ROW    = 24'h00_0000 // Page held at power-up
)(
   input  wire logic        core_clk,
   input  wire logic [15:0] busy_len,
   input  wire nrs_pin_t    pins,
   output logic      [7:0]  io_i,
   output logic             ready_busy_n
);
   logic [15:0] bcnt = 16'h0000;   // Busy countdown
   logic [1:0]  mode = 2'd0;       // Read mode at power-up
   logic [7:0]  abuf [0:4];        // Address bytes
   logic [2:0]  acnt = 3'h0;       // Address byte count
   logic [11:0] col  = 12'h000;    // Output pointer
   logic [11:0] scol = 12'h000;    // Addressed start column
   logic [23:0] drow = BOOT_ROW;   // Page in data register
   logic [23:0] orow = BOOT_ROW;   // Page in output register
   logic [2:0]  idx  = 3'h0;       // Identifier byte index
   logic [7:0]  idt  [0:4];        // Identifier table
   initial io_i = 8'h5A;
   initial idt = '{MAKER_CODE, DEVICE_CODE, 8'h90, 8'h95, 8'h54};
   function automatic logic [7:0] pdat(input logic [23:0] r, input logic [11:0] c);
      return r[7:0] ^ c[7:0] ^ {4'h0, c[11:8]};
   endfunction
   ////////////////////////////////////////////////////////////////
   // Busy line counts down array transfers
   assign ready_busy_n = (bcnt == 16'h0000);
   always @(posedge core_clk) begin
      if (bcnt != 16'h0000) begin
         bcnt <= bcnt - 16'h0001;
      end
   end
   ////////////////////////////////////////////////////////////////
   // Command and address cycles latch on write strobe rise
   always @(posedge pins.we_n) begin
      if (!pins.ce_n && pins.ale) begin
         abuf[acnt] = pins.io_o;
         acnt = acnt + 3'h1;
      end else if (!pins.ce_n && pins.cle) begin
         acnt = 3'h0;
         mode = 2'd0; // Any command leaves identifier mode
         case (pins.io_o)
            8'h00: col = scol;
            8'h30: begin
               scol = {abuf[1][3:0], abuf[0]};
               col = scol;
               drow = {abuf[4], abuf[3], abuf[2]};
               orow = drow;
               bcnt = busy_len;
            end
            8'hE0: col = {abuf[1][3:0], abuf[0]};
            8'h31: begin
               orow = drow;
               drow = drow + 24'h00_0001;
               col = 12'h000;
               bcnt = busy_len;
            end
            8'h3F: begin
               orow = drow;
               col = 12'h000;
               bcnt = busy_len;
            end
            8'h90: begin
               mode = 2'd2;
               idx = 3'h0;
            end
            8'h70: mode = 2'd1;
            default: ;
         endcase
      end
   end
   ////////////////////////////////////////////////////////////////
   // Byte out on strobe fall, bus scrambled on release
   always @(negedge pins.read_strobe_n) begin
      if (!pins.ce_n) begin
         case (mode)
            2'd1: io_i = {1'b1, ready_busy_n, ready_busy_n, 5'h00};
            2'd2: io_i = idt[idx];
            default: io_i = pdat(orow, col);
         endcase
      end
   end
   // Only a selected strobe rise steps, so the pin settling out of reset is ignored
   always @(posedge pins.read_strobe_n) begin
      io_i = ~io_i;
      if (!pins.ce_n && mode == 2'd2 && idx < 3'h4) begin
         idx = idx + 3'h1;
      end
      if (!pins.ce_n && mode == 2'd0 && col < 12'h83F) begin
         col = col + 12'h001;
      end
   end
endmodule

// ==== verif/tb.sv ====
`timescale 1ns/1ps
`include "nrs_params.svh"
// Self-checking bench: APB driver, flash model, result queue
module tb
   import nrs_pkg::*;
;
   localparam logic [7:0]  MAKER = 8'h5A;       // Arbitrary maker value
   localparam logic [7:0]  DEVC  = 8'hA5;       // Arbitrary device value
   localparam logic [23:0] BOOT  = 24'h00_00C3; // Page held at power-up
   logic        core_clk = 1'b0;
   logic        rst      = 1'b1;
   logic        psel     = 1'b0;
   logic        penable  = 1'b0;
   logic        pwrite   = 1'b0;
   logic        want     = 1'b0;
   logic [7:0]  paddr    = 8'h00;
   logic [31:0] pwdata   = 32'h0000_0000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [7:0]  io_i;
   logic        ready_busy_n;
   nrs_pin_t    pins;
   logic [15:0] bl       = 16'h0003;
   logic [32:0] exp_q [$];
   logic [23:0] row;
   logic [11:0] col;
   logic [11:0] ncol;
   logic [7:0]  idb [0:4];
   int          num_errors  = 0;
   int          checks_done = 0;
   always #12.5 core_clk = ~core_clk;
   nrs_host u_nrs_host (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .io_i(io_i), .ready_busy_n(ready_busy_n), .pins(pins));
   nrs_flash_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVC), .BOOT_ROW(BOOT))
      u_nrs_flash_model (.core_clk(core_clk), .busy_len(bl), .pins(pins), .io_i(io_i),
      .ready_busy_n(ready_busy_n));
   ////////////////////////////////////////////////////////////////
   function automatic logic [7:0] eb(input logic [23:0] r, input logic [11:0] c);
      return r[7:0] ^ c[7:0] ^ {4'h0, c[11:8]};
   endfunction
   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // One APB transfer, held until pready
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                      input logic chk, output logic [31:0] q);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      want <= chk;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1) @(posedge core_clk);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      apb(a, 1'b1, d, 1'b0, q);
   endtask
   task automatic rd(input logic [7:0] a, input logic [32:0] e);
      logic [31:0] q;
      exp_q.push_back(e);
      apb(a, 1'b0, 32'h0000_0000, 1'b1, q);
   endtask
   task automatic wait_idle();
      logic [31:0] q;
      for (int i = 0; i < 300; i++) begin
         apb(`NRS_REG_STAT, 1'b0, 32'h0000_0000, 1'b0, q);
         if (q[`NRS_ST_BUSY] === 1'b0) return;
      end
      num_errors++;
   endtask
   task automatic op(input logic [2:0] o);
      wr(`NRS_REG_CMD, {29'h0, o});
      wait_idle();
   endtask
   task automatic rdb(input logic [7:0] e);
      op(`NRS_OP_BYTE);
      rd(`NRS_REG_DATA, {25'h0, e});
   endtask
   // Compare every checked read against the oldest note
   always @(posedge core_clk) begin
      if (psel && penable && pready && !pwrite && want) begin
         check({pslverr, prdata}, exp_q.pop_front());
      end
   end
   initial begin
      #(25 * 40000);
      num_errors++;
      test_done();
   end
   ////////////////////////////////////////////////////////////////
   initial begin
      idb = '{MAKER, DEVC, 8'h90, 8'h95, 8'h54};
      void'($urandom(79));
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      repeat (3) @(posedge core_clk);
      rd(`NRS_REG_STAT, 33'h0_0000_0002);
      rd(8'hFC, 33'h1_0000_0000);
      rdb(eb(BOOT, 12'h000));
      for (int k = 0; k < 3; k++) begin
         bl <= (k == 1) ? 16'h003C : 16'h0003;
         row = {24'($urandom) & 24'hFF_FFC0} | 24'($urandom_range(0, 60));
         col = 12'($urandom_range(0, 2100));
         ncol = (k == 0) ? 12'h83E : 12'($urandom_range(0, 2100));
         wr(`NRS_REG_COL, {20'h0_0000, col});
         wr(`NRS_REG_ROW, {8'h00, row});
         op(`NRS_OP_PAGE);
         rd(`NRS_REG_STAT, 33'h0_0000_0022);
         for (int j = 0; j < 3; j++) rdb(eb(row, col + 12'(j)));
         wr(`NRS_REG_COL, {20'h0_0000, ncol});
         op(`NRS_OP_RANDOM);
         for (int j = 0; j < 3; j++) begin
            rdb(eb(row, (ncol + 12'(j) > 12'h83F) ? 12'h83F : ncol + 12'(j)));
         end
         op(`NRS_OP_STATUS);
         rdb(8'hE0);
         op(`NRS_OP_RDMODE);
         rdb(eb(row, col));
         op(`NRS_OP_CACHE);
         rdb(eb(row, 12'h000));
         op(`NRS_OP_CACHE);
         rdb(eb(row + 24'h00_0001, 12'h000));
         op(`NRS_OP_LAST);
         rdb(eb(row + 24'h00_0002, 12'h000));
         op(`NRS_OP_ID);
         for (int j = 0; j < 5; j++) rdb(idb[j]);
         op(`NRS_OP_RDMODE);
         rdb(eb(row + 24'h00_0002, col));
      end
      wr(`NRS_REG_ROW, {8'h00, row | 24'h00_003F});
      op(`NRS_OP_PAGE);
      op(`NRS_OP_CACHE);
      rd(`NRS_REG_STAT, 33'h0_0000_002A);
      wr(`NRS_REG_STAT, 32'h0000_0008);
      rd(`NRS_REG_STAT, 33'h0_0000_0022);
      bl <= 16'h003C;
      wr(`NRS_REG_CMD, {29'h0, `NRS_OP_PAGE});
      wr(`NRS_REG_CMD, {29'h0, `NRS_OP_RANDOM});
      wait_idle();
      rd(`NRS_REG_STAT, 33'h0_0000_002A);
      test_done();
   end
endmodule
